//--- inc/sleep_wakeup_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SLEEP_WAKEUP_DEFINES_SVH
`define SLEEP_WAKEUP_DEFINES_SVH

`define SW_CTRL_OFS        8'h00
`define SW_STAT_OFS        8'h04
`define SW_IRQ_STAT_OFS    8'h08
`define SW_IRQ_MASK_OFS    8'h0C
`define SW_CTRL_RST        32'h0000_0001
`define SW_CTRL_WDT_EN     0
`define SW_CTRL_CRYSTAL    1
`define SW_CTRL_GIE        2
`define SW_CTRL_EN_EXT     3
`define SW_CTRL_EN_PORT    4
`define SW_CTRL_EN_CMP     5
`define SW_CTRL_SLEEP      8
`define SW_CTRL_RETFIE     9
`define SW_EVT_WAKE_WDT    0
`define SW_EVT_WAKE_IRQ    1
`define SW_EVT_WAKE_RST    2
`define SW_EVT_WDT_RESET   3
`define SW_OSC_DELAY_TOSC  1024
`define SW_OSC_DELAY_CYC   11'd1024
`define SW_WDT_PERIOD      16'hFFFF
`define SW_VECTOR_ADDR     13'h0004
`define SW_DUMMY_CYC       2'd2

`endif

//--- inc/sleep_wakeup_pkg.sv
// Types shared by the sleep and wake-up controller
package sleep_wakeup_pkg;
   typedef enum logic [2:0] {
      ST_RUN    = 3'b000,
      ST_SLEEP  = 3'b001,
      ST_OSCWT  = 3'b010,
      ST_PREEX  = 3'b011,
      ST_DUMMY  = 3'b100
   } pwr_state_t;

   typedef struct packed {
      logic extIrq;
      logic portChange;
      logic cmpIrq;
   } irq_src_t;

   typedef struct packed {
      logic        fetchEn;
      logic        loadVector;
      logic [12:0] vectorAddr;
      logic        pushReturn;
   } core_ctl_t;
endpackage

//--- rtl/sleep_wakeup_control.sv
// Sleep entry, wake-up sequencing and watchdog for a small core
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "sleep_wakeup_defines.svh"

module sleep_wakeup_control
   import sleep_wakeup_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        haddrSel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        masterResetPin,
   input  wire irq_src_t    irqPins,
   input  wire logic        retireDone,
   input  wire logic [7:0]  ioOutIn,
   input  wire logic [7:0]  ioOeIn,
   output logic      [7:0]  ioOut,
   output logic      [7:0]  ioOe,
   output logic             oscDriverEn,
   output logic             coreClkEn,
   output logic             fullReset,
   output core_ctl_t        coreCtl,
   output logic             irq
);

   pwr_state_t  state_ff;
   pwr_state_t  nxt_state;
   logic [1:0]  rstSync_ff;
   logic [2:0]  irq0_ff;
   logic [2:0]  irqSync_ff;
   irq_src_t    irqFlag_ff;
   logic [31:0] ctrl_ff;
   logic        pdFlag_ff;
   logic        toFlag_ff;
   logic [3:0]  evtStat_ff;
   logic [3:0]  evtMask_ff;
   logic [3:0]  evtSet;
   logic [15:0] wdt_ff;
   logic [10:0] oscCnt_ff;
   logic [1:0]  dummyCnt_ff;
   logic        wdtExpire;
   logic        irqWake;
   logic        pinWake;
   logic        sleepReq;
   logic        busWr_ff;
   logic        busRd_ff;
   logic [7:0]  busAddr_ff;
   logic        accept;
   logic [2:0]  irqEnables;

   // Pins cross into mclk through two flops before any logic reads them
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstSync_ff <= 2'h3;
         irq0_ff    <= 3'h0;
         irqSync_ff <= 3'h0;
      end else begin
         rstSync_ff <= {rstSync_ff[0], masterResetPin};
         irq0_ff    <= irqPins;
         irqSync_ff <= irq0_ff;
      end
   end

   assign irqEnables = {ctrl_ff[`SW_CTRL_EN_EXT], ctrl_ff[`SW_CTRL_EN_PORT],
                        ctrl_ff[`SW_CTRL_EN_CMP]};
   assign pinWake  = ~rstSync_ff[1];
   // Wake is independent of the global enable
   assign irqWake  = |(irqFlag_ff & irqEnables);
   assign wdtExpire = ctrl_ff[`SW_CTRL_WDT_EN] && wdt_ff == `SW_WDT_PERIOD;
   assign sleepReq = ctrl_ff[`SW_CTRL_SLEEP];
   assign accept   = haddrSel && htrans[1] && hready;

   // Interrupt source flags latch regardless of enables
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irqFlag_ff <= '0;
      end else begin
         irqFlag_ff <= irqFlag_ff | irqSync_ff;
         if (busWr_ff && busAddr_ff == `SW_STAT_OFS) begin
            irqFlag_ff <= (irqFlag_ff & ~hwdata[6:4]) | irqSync_ff;
         end
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (sleepReq && retireDone) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // Pending enabled source wakes on the very next cycle
            if (irqWake || wdtExpire) begin
               nxt_state = ctrl_ff[`SW_CTRL_CRYSTAL] ? ST_OSCWT : ST_PREEX;
            end
         end
         ST_OSCWT: begin
            if (oscCnt_ff == `SW_OSC_DELAY_CYC - 11'd1) begin
               nxt_state = ST_PREEX;
            end
         end
         ST_PREEX: begin
            if (retireDone) begin
               nxt_state = (ctrl_ff[`SW_CTRL_GIE] && irqWake) ?
                           ST_DUMMY : ST_RUN;
            end
         end
         ST_DUMMY: begin
            if (dummyCnt_ff == `SW_DUMMY_CYC - 2'd1) begin
               nxt_state = ST_RUN;
            end
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_RUN;
      end else if (pinWake) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         oscCnt_ff   <= '0;
         dummyCnt_ff <= '0;
      end else begin
         oscCnt_ff   <= (state_ff == ST_OSCWT) ? oscCnt_ff + 11'd1 : 11'd0;
         dummyCnt_ff <= (state_ff == ST_DUMMY) ? dummyCnt_ff + 2'd1 : 2'd0;
      end
   end

   // Watchdog: cleared on entry and on every exit except a reset-pin wake, counts through sleep
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wdt_ff <= '0;
      end else if (!ctrl_ff[`SW_CTRL_WDT_EN]) begin
         wdt_ff <= '0;
      end else if (state_ff == ST_RUN && nxt_state == ST_SLEEP) begin
         wdt_ff <= '0;
      end else if (state_ff == ST_SLEEP && nxt_state != ST_SLEEP) begin
         wdt_ff <= '0;
      end else if (wdtExpire) begin
         wdt_ff <= '0;
      end else begin
         wdt_ff <= wdt_ff + 16'd1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pdFlag_ff <= 1'b1;
         toFlag_ff <= 1'b1;
      end else if (pinWake) begin
         pdFlag_ff <= 1'b1;
         toFlag_ff <= 1'b1;
      end else if (state_ff == ST_RUN && nxt_state == ST_SLEEP) begin
         pdFlag_ff <= 1'b0;
         toFlag_ff <= 1'b1;
      end else if (state_ff == ST_SLEEP && wdtExpire) begin
         toFlag_ff <= 1'b0;
      end else if (state_ff == ST_RUN && wdtExpire) begin
         toFlag_ff <= 1'b0;
      end
   end

   // Clock gate and pin hold
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         oscDriverEn <= 1'b1;
         coreClkEn   <= 1'b1;
         ioOut       <= '0;
         ioOe        <= '0;
      end else begin
         oscDriverEn <= (nxt_state != ST_SLEEP) || pinWake;
         coreClkEn   <= nxt_state == ST_RUN || nxt_state == ST_PREEX;
         if (nxt_state != ST_SLEEP && nxt_state != ST_OSCWT) begin
            ioOut <= ioOutIn;
            ioOe  <= ioOeIn;
         end
      end
   end

   // Watchdog reset is internal only; the reset pin is never driven
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fullReset <= 1'b1;
      end else begin
         fullReset <= pinWake || (state_ff == ST_RUN && wdtExpire);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         coreCtl <= '0;
      end else begin
         coreCtl.fetchEn    <= nxt_state == ST_RUN || state_ff == ST_RUN;
         coreCtl.loadVector <= state_ff == ST_DUMMY && nxt_state == ST_RUN;
         coreCtl.pushReturn <= state_ff == ST_DUMMY && nxt_state == ST_RUN;
         coreCtl.vectorAddr <= `SW_VECTOR_ADDR;
      end
   end

   // Control register; sleep request self-clears once taken
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= `SW_CTRL_RST;
      end else begin
         if (busWr_ff && busAddr_ff == `SW_CTRL_OFS) begin
            ctrl_ff <= hwdata;
         end
         if (state_ff == ST_RUN && nxt_state == ST_SLEEP) begin
            ctrl_ff[`SW_CTRL_SLEEP] <= 1'b0;
         end
         if (state_ff == ST_DUMMY && nxt_state == ST_RUN) begin
            ctrl_ff[`SW_CTRL_GIE] <= 1'b0;
         end
         if (busWr_ff && busAddr_ff == `SW_CTRL_OFS
             && hwdata[`SW_CTRL_RETFIE]) begin
            ctrl_ff[`SW_CTRL_GIE]    <= 1'b1;
            ctrl_ff[`SW_CTRL_RETFIE] <= 1'b0;
         end
      end
   end

   assign evtSet = {state_ff == ST_RUN && wdtExpire,
                    pinWake && state_ff != ST_RUN,
                    state_ff == ST_SLEEP && irqWake && !wdtExpire,
                    state_ff == ST_SLEEP && wdtExpire};

   // Read clears status; a same-cycle event wins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         evtStat_ff <= '0;
         evtMask_ff <= '0;
      end else begin
         if (busRd_ff && busAddr_ff == `SW_IRQ_STAT_OFS) begin
            evtStat_ff <= evtSet;
         end else begin
            evtStat_ff <= evtStat_ff | evtSet;
         end
         if (busWr_ff && busAddr_ff == `SW_IRQ_MASK_OFS) begin
            evtMask_ff <= hwdata[3:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evtStat_ff & evtMask_ff) || |(evtSet & evtMask_ff);
      end
   end

   // AHB-Lite slave, zero wait states
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busWr_ff   <= 1'b0;
         busRd_ff   <= 1'b0;
         busAddr_ff <= '0;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end else begin
         busWr_ff   <= accept && hwrite;
         busRd_ff   <= accept && !hwrite;
         busAddr_ff <= accept ? haddr[7:0] : busAddr_ff;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= '0;
      end else if (accept && !hwrite) begin
         unique case (haddr[7:0])
            `SW_CTRL_OFS:     hrdata <= ctrl_ff;
            `SW_STAT_OFS:     hrdata <= {25'h0, irqFlag_ff,
                                         2'h0, pdFlag_ff, toFlag_ff};
            `SW_IRQ_STAT_OFS: hrdata <= {28'h0, evtStat_ff | evtSet};
            `SW_IRQ_MASK_OFS: hrdata <= {28'h0, evtMask_ff};
            default:          hrdata <= 32'h0000_0000;
         endcase
      end
   end

   a_sleep_clears_pd: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == ST_RUN && nxt_state == ST_SLEEP && !pinWake
      |=> !pdFlag_ff && toFlag_ff)
      else $error("sleep entry flags wrong");
   a_osc_off_sleep: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == ST_SLEEP && !pinWake |-> !oscDriverEn)
      else $error("oscillator running in sleep");
   a_osc_wait_len: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(state_ff == ST_OSCWT) && !pinWake
      |-> (state_ff == ST_OSCWT || pinWake) [*8])
      else $error("oscillator wait too short");
   a_wdt_wake_to: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == ST_SLEEP && wdtExpire && !pinWake |=> !toFlag_ff)
      else $error("timeout flag not cleared");
   a_wdt_exit_clr: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == ST_SLEEP && nxt_state != ST_SLEEP |=> wdt_ff == 16'h0)
      else $error("watchdog not cleared on wake");
   a_pin_reset: assert property (@(posedge mclk) disable iff (!resetn)
      pinWake |=> fullReset && state_ff == ST_RUN)
      else $error("pin wake without reset");
   a_vector_path: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == ST_DUMMY && $past(state_ff) == ST_PREEX && !pinWake
      |=> state_ff == ST_DUMMY ##1 coreCtl.loadVector)
      else $error("vector not after two dummies");
   a_no_irq_wake: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == ST_SLEEP && !irqWake && !wdtExpire && !pinWake
      |=> state_ff == ST_SLEEP)
      else $error("spurious wake");

endmodule

//--- sim/wake_source_model.sv
// Model of the external reset pin and the interrupt source pins
`timescale 1ns/1ps
module wake_source_model
   import sleep_wakeup_pkg::*;
(
   input  wire logic mclk,
   output logic      masterResetPin,
   output irq_src_t  irqPins
);
   initial begin
      masterResetPin = 1'b1;
      irqPins        = '0;
   end

   // Pulses last several clocks so the two-flop synchroniser sees them
   task automatic pulse_irq(input int idx);
      @(posedge mclk);
      irqPins[idx] <= 1'b1;
      repeat (4) @(posedge mclk);
      irqPins[idx] <= 1'b0;
   endtask

   task automatic pulse_reset;
      @(posedge mclk);
      masterResetPin <= 1'b0;
      repeat (4) @(posedge mclk);
      masterResetPin <= 1'b1;
   endtask
endmodule

//--- sim/test_sleep_wakeup_control.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
`include "sleep_wakeup_defines.svh"
module test_sleep_wakeup_control
   import sleep_wakeup_pkg::*;
;
   typedef struct {
      logic [31:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } row_t;

   localparam logic [31:0] aCtrl = {24'h0, `SW_CTRL_OFS};
   localparam logic [31:0] aStat = {24'h0, `SW_STAT_OFS};
   localparam logic [31:0] aEvt  = {24'h0, `SW_IRQ_STAT_OFS};
   localparam logic [31:0] aMask = {24'h0, `SW_IRQ_MASK_OFS};

   logic        mclk = 1'b0;
   logic        resetn;
   logic        haddrSel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        masterResetPin;
   irq_src_t    irqPins;
   logic        retireDone;
   logic [7:0]  ioOutIn;
   logic [7:0]  ioOeIn;
   logic [7:0]  ioOut;
   logic [7:0]  ioOe;
   logic        oscDriverEn;
   logic        coreClkEn;
   logic        fullReset;
   core_ctl_t   coreCtl;
   logic        irq;
   logic [31:0] rd;
   int          n;
   int          err_total = 0;
   int          n_checks = 0;

   // Register behaviour rows: write d to a, then read back expecting e
   row_t rows [6] = '{
      '{aCtrl, 32'h0000_003E, 32'h0000_003E},
      '{aCtrl, 32'h0000_0000, 32'h0000_0000},
      '{aMask, 32'h0000_000F, 32'h0000_000F},
      '{32'h0000_0040, 32'hFFFF_FFFF, 32'h0000_0000},
      '{aStat, 32'h0000_0000, 32'h0000_0003},
      '{aEvt, 32'h0000_0000, 32'h0000_0000}
   };

   always #4 mclk = ~mclk;
   assign hready = hreadyout;

   sleep_wakeup_control u_dut (
      .mclk(mclk), .resetn(resetn), .haddrSel(haddrSel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .masterResetPin(masterResetPin), .irqPins(irqPins),
      .retireDone(retireDone), .ioOutIn(ioOutIn), .ioOeIn(ioOeIn),
      .ioOut(ioOut), .ioOe(ioOe), .oscDriverEn(oscDriverEn),
      .coreClkEn(coreClkEn), .fullReset(fullReset), .coreCtl(coreCtl),
      .irq(irq)
   );

   wake_source_model u_src (
      .mclk(mclk), .masterResetPin(masterResetPin), .irqPins(irqPins)
   );

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Single word transfer; the address phase is held until hready is seen
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      haddrSel <= 1'b1;
      htrans   <= 2'b10;
      haddr    <= a;
      hwrite   <= wr;
      hsize    <= 3'b010;
      do @(posedge mclk); while (hready !== 1'b1);
      haddrSel <= 1'b0;
      htrans   <= 2'b00;
      hwdata   <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // Sample just after the edge so registered outputs have settled
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic waitOsc(input logic v, input int lim);
      n = 0;
      while (oscDriverEn !== v && n < lim) begin
         tick(1);
         n++;
      end
      chk("oscDriverEn", {31'h0, v}, {31'h0, oscDriverEn});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge mclk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      resetn = 1'b0; haddrSel = 1'b0; haddr = '0; htrans = '0;
      hwrite = 1'b0; hsize = '0; hwdata = '0; retireDone = 1'b1;
      ioOutIn = 8'hA5; ioOeIn = 8'h0F;
      tick(5);
      chk("fullReset in reset", 32'h1, {31'h0, fullReset});
      chk("osc in reset", 32'h1, {31'h0, oscDriverEn});
      @(posedge mclk);
      resetn <= 1'b1;
      bus(0, aCtrl, 32'h0);
      chk("ctrl reset", `SW_CTRL_RST, rd);
      bus(0, aStat, 32'h0);
      chk("stat reset", 32'h3, rd);
      chk("fullReset released", 32'h0, {31'h0, fullReset});
      foreach (rows[i]) begin
         bus(1, rows[i].a, rows[i].d);
         bus(0, rows[i].a, 32'h0);
         chk("table read", rows[i].e, rd);
      end
      // Sleep with only the port change source enabled
      bus(1, aCtrl, 32'h110);
      waitOsc(0, 20);
      tick(2);
      chk("core clock asleep", 32'h0, {31'h0, coreClkEn});
      chk("fetch stopped", 32'h0, {31'h0, coreCtl.fetchEn});
      @(posedge mclk);
      ioOutIn <= 8'h3C;
      ioOeIn  <= 8'hF0;
      tick(2);
      chk("held pins", 32'hA50F, {16'h0, ioOut, ioOe});
      bus(0, aStat, 32'h0);
      chk("flags asleep", 32'h1, rd);
      u_src.pulse_irq(2);
      tick(20);
      chk("disabled source", 32'h0, {31'h0, oscDriverEn});
      u_src.pulse_irq(1);
      waitOsc(1, 20);
      n = 0;
      repeat (30) begin
         tick(1);
         if (coreCtl.loadVector !== 1'b0) n++;
      end
      chk("no vector", 32'h0, n);
      chk("core clock awake", 32'h1, {31'h0, coreClkEn});
      chk("pins follow", 32'h3CF0, {16'h0, ioOut, ioOe});
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(0, aEvt, 32'h0);
      chk("irq wake event", 32'h2, rd);
      tick(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      bus(1, aStat, 32'h70);
      // Enabled flag already pending when the sleep request lands
      u_src.pulse_irq(2);
      tick(6);
      bus(1, aCtrl, 32'h108);
      tick(20);
      chk("immediate wake", 32'h1, {31'h0, coreClkEn});
      bus(1, aMask, 32'h0);
      tick(2);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1, aMask, 32'hF);
      tick(2);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      bus(0, aEvt, 32'h0);
      chk("pending wake event", 32'h2, rd);
      bus(1, aStat, 32'h70);
      // Crystal mode, global enable set, comparator wake
      bus(1, aCtrl, 32'h126);
      waitOsc(0, 20);
      u_src.pulse_irq(0);
      // Settle the edge that ends the pulse so the wait is counted in full
      tick(0);
      waitOsc(1, 20);
      n = 0;
      while (coreClkEn !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk("osc delay", 32'h1, 32'(n >= 1024 && n <= 1030));
      n = 0;
      while (coreCtl.loadVector !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("dummy gap", 32'h1, 32'(n >= 3 && n <= 5));
      chk("vector", {19'h0, `SW_VECTOR_ADDR},
          {19'h0, coreCtl.vectorAddr});
      chk("fetch running", 32'h1, {31'h0, coreCtl.fetchEn});
      chk("push", 32'h1, {31'h0, coreCtl.pushReturn});
      bus(0, aCtrl, 32'h0);
      chk("enable cleared", 32'h22, rd);
      bus(1, aStat, 32'h70);
      bus(0, aEvt, 32'h0);
      // Watchdog wake
      bus(1, aCtrl, 32'h101);
      waitOsc(0, 20);
      waitOsc(1, 70000);
      chk("wdt from entry", 32'h1, 32'(n >= 65000));
      bus(0, aStat, 32'h0);
      chk("timeout cleared", 32'h0, rd);
      bus(0, aEvt, 32'h0);
      chk("wdt wake event", 32'h1, rd);
      // Reset pin wake
      bus(1, aCtrl, 32'h100);
      waitOsc(0, 20);
      u_src.pulse_reset();
      n = 0;
      while (fullReset !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("pin reset", 32'h1, {31'h0, fullReset});
      tick(20);
      chk("running after pin", 32'h1, {31'h0, coreClkEn});
      chk("hresp okay", 32'h0, {31'h0, hresp});
      tally_and_finish();
   end
endmodule
